// File: src/asft_pkg.sv
// Shared constants and types for the sample buffer link and its two ends.
package asft_pkg;

  // ****************************************************************
  // Buffer geometry and device register map
  // ****************************************************************
  localparam int          FIFO_DEPTH      = 32;
  localparam int          SAMPLE_W        = 48;
  localparam logic [5:0]  ADDR_AXIS_FIRST = 6'h32;
  localparam logic [5:0]  ADDR_AXIS_LAST  = 6'h37;
  localparam logic [5:0]  ADDR_CTRL       = 6'h38;
  localparam logic [5:0]  ADDR_STATUS     = 6'h39;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam int          CTRL_MODE_HI    = 7;
  localparam int          CTRL_MODE_LO    = 6;
  localparam int          CTRL_TRIG_SEL   = 5;
  localparam int          CTRL_LEVEL_HI   = 4;
  localparam int          STATUS_TRIG_BIT = 7;
  localparam int          CMD_READ_BIT    = 7;
  localparam int          CMD_BURST_BIT   = 6;

  // Buffer modes held in the control byte.
  typedef enum logic [1:0] {
    MODE_BYPASS  = 2'h0,
    MODE_FIFO    = 2'h1,
    MODE_STREAM  = 2'h2,
    MODE_TRIGGER = 2'h3
  } asft_mode_e;

  // ****************************************************************
  // Host controller registers and timing
  // ****************************************************************
  localparam logic [7:0]  HREG_CMD        = 8'h00;
  localparam logic [7:0]  HREG_RX_LO      = 8'h04;
  localparam logic [7:0]  HREG_RX_HI      = 8'h08;
  localparam logic [7:0]  HREG_STATUS     = 8'h0C;
  localparam int          HCMD_WDATA_LO   = 8;
  localparam int          HCMD_LEN_LO     = 16;
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          POP_DELAY_NS    = 5000;
  localparam int          POP_DELAY_CYC   =
    (POP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          SCLK_HALF_DEF   = 20;
  localparam int          SCLK_HALF_MIN   = 8;

endpackage

// File: src/asft_link_if.sv
// Four-wire serial link between the host controller and the sensor buffer.
`timescale 1ns/1ps
interface asft_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport dev  (input sclk, input cs_n, input mosi,
                output miso, output miso_oe);
  modport host (output sclk, output cs_n, output mosi,
                input miso, input miso_oe);
endinterface

// File: src/asft_ring.sv
// Sample storage array with one write port and one combinational read port.
`timescale 1ns/1ps
module asft_ring #(
  parameter int W     = 48,
  parameter int DEPTH = 32
) (
  // Clock.
  input  wire logic                     clk,
  // Write side.
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_data,
  // Read side.
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [W-1:0]             rd_data
);

  logic [W-1:0] mem [DEPTH];

  // Storage has no reset; occupancy logic never reads an unwritten slot.
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  assign rd_data = mem[rd_idx];
endmodule // asft_ring

// File: src/asft_dev_end.sv
// Sensor end: sample buffer with bypass, FIFO, stream and trigger modes.
//
// Implementation choice: a four-wire serial slave port.
`timescale 1ns/1ps
module asft_dev_end #(
  parameter int DEPTH = asft_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  // Measurement path.
  input  wire logic                          sample_valid,
  input  wire logic [asft_pkg::SAMPLE_W-1:0] sample_data,
  input  wire logic                          trigger_event,
  // Event outputs.
  output logic                               interrupt_out_one,
  output logic                               interrupt_out_two,
  output logic                               watermark,
  output logic                               overrun,
  // Serial link.
  asft_link_if.dev                           link
);

  localparam int PW = $clog2(DEPTH);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (DEPTH < 2 || DEPTH > 32 || (1 << PW) != DEPTH)
    $error("DEPTH must be a power of two from 2 to 32");

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]                  s1;
    logic [2:0]                  s2;
    logic [2:0]                  s3;
    logic [2:0]                  pin;
    logic [2:0]                  bit_cnt;
    logic [7:0]                  rx;
    logic [7:0]                  tx;
    logic                        cmd_phase;
    logic                        is_read;
    logic                        burst;
    logic                        out_touched;
    logic [5:0]                  addr;
    logic                        miso;
    logic                        miso_oe;
    logic [7:0]                  ctrl;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
    logic [asft_pkg::SAMPLE_W-1:0] holder;
    logic                        holder_valid;
    logic                        triggered;
    logic                        overrun;
    logic                        watermark;
    logic                        int_one;
    logic                        int_two;
  } asft_dev_s;

  // Idle link levels: clock high, deselected, data low.
  localparam logic [2:0] PIN_IDLE = 3'h6;

  asft_dev_s                     q;
  asft_dev_s                     n;
  logic                          wr_en;
  logic [asft_pkg::SAMPLE_W-1:0] rd_data;

  asft_ring #(
    .W     (asft_pkg::SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_ring (
    .clk     (ref_clk),
    .wr_en   (wr_en),
    .wr_idx  (q.wr_ptr),
    .wr_data (sample_data),
    .rd_idx  (q.rd_ptr),
    .rd_data (rd_data)
  );

  // Register read mux; the axis bytes always come from the holder.
  function automatic logic [7:0] reg_rd(input logic [5:0] a,
                                        input asft_dev_s s);
    logic [7:0] r;
    r = 8'h00;
    if (a >= asft_pkg::ADDR_AXIS_FIRST && a <= asft_pkg::ADDR_AXIS_LAST)
      r = s.holder[8*(a - asft_pkg::ADDR_AXIS_FIRST) +: 8];
    else if (a == asft_pkg::ADDR_CTRL)
      r = s.ctrl;
    else if (a == asft_pkg::ADDR_STATUS)
      r = {s.triggered, 1'b0, 6'(s.count)};
    return r;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic [2:0]          stable;
    logic [2:0]          chg;
    logic                mosi_v;
    logic [7:0]          byte_v;
    logic                load;
    logic                end_read;
    logic                wr_ctrl;
    logic                drop;
    logic [PW:0]         level;
    asft_pkg::asft_mode_e mode;
    n        = q;
    wr_en    = 1'b0;
    load     = 1'b0;
    end_read = 1'b0;
    wr_ctrl  = 1'b0;
    byte_v   = 8'h00;
    drop     = 1'b0;
    // Three-stage capture; a level counts once stages two and three agree.
    n.s1     = {link.sclk, link.cs_n, link.mosi};
    n.s2     = q.s1;
    n.s3     = q.s2;
    stable   = ~(q.s2 ^ q.s3);
    chg      = stable & (q.s3 ^ q.pin);
    n.pin    = (stable & q.s3) | (~stable & q.pin);
    mosi_v   = n.pin[0];
    // Select edge restarts byte framing; deselect ends an output read.
    if (chg[1] && !q.s3[1])
    begin
      n.bit_cnt     = 3'h0;
      n.cmd_phase   = 1'b1;
      n.out_touched = 1'b0;
      n.tx          = 8'h00;
    end
    if (chg[1] && q.s3[1] && q.out_touched)
    begin
      end_read      = 1'b1;
      n.out_touched = 1'b0;
    end
    n.miso_oe = ~n.pin[1];
    // Output data changes on the falling clock edge.
    if (!q.pin[1] && chg[2] && !q.s3[2])
    begin
      n.miso = q.tx[7];
      n.tx   = {q.tx[6:0], 1'b0};
    end
    // Input data is taken on the rising clock edge.
    if (!q.pin[1] && chg[2] && q.s3[2])
    begin
      n.rx      = {q.rx[6:0], mosi_v};
      n.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7)
      begin
        byte_v      = {q.rx[6:0], mosi_v};
        n.cmd_phase = 1'b0;
        if (q.cmd_phase)
        begin
          n.is_read = byte_v[asft_pkg::CMD_READ_BIT];
          n.burst   = byte_v[asft_pkg::CMD_BURST_BIT];
          n.addr    = byte_v[5:0];
          load      = byte_v[asft_pkg::CMD_READ_BIT];
        end
        else
        begin
          wr_ctrl = !q.is_read && q.addr == asft_pkg::ADDR_CTRL;
          if (q.burst)
            n.addr = q.addr + 6'h01;
          if (q.is_read && q.burst && q.addr == asft_pkg::ADDR_AXIS_LAST)
          begin
            end_read      = 1'b1;
            n.out_touched = 1'b0;
          end
          load = q.is_read && q.burst;
        end
        if (load)
        begin
          n.tx = reg_rd(n.addr, q);
          if (n.addr >= asft_pkg::ADDR_AXIS_FIRST &&
              n.addr <= asft_pkg::ADDR_AXIS_LAST)
            n.out_touched = 1'b1;
        end
      end
    end
    // Control write; entering bypass flushes and re-arms the trigger.
    if (wr_ctrl)
    begin
      n.ctrl = byte_v;
      if (byte_v[asft_pkg::CTRL_MODE_HI:asft_pkg::CTRL_MODE_LO] ==
          asft_pkg::MODE_BYPASS)
      begin
        n.wr_ptr    = '0;
        n.rd_ptr    = '0;
        n.count     = '0;
        n.triggered = 1'b0;
        n.overrun   = 1'b0;
        // A held entry is flushed too, so it cannot reappear later.
        n.holder_valid = 1'b0;
      end
    end
    mode  = asft_pkg::asft_mode_e'(
              n.ctrl[asft_pkg::CTRL_MODE_HI:asft_pkg::CTRL_MODE_LO]);
    level = (PW+1)'(n.ctrl[asft_pkg::CTRL_LEVEL_HI:0]);
    // A finished read consumes the whole held sample, read or not.
    if (end_read && mode != asft_pkg::MODE_BYPASS)
      n.holder_valid = 1'b0;
    // Pop the oldest entry into the output bytes once they are free.
    if (mode != asft_pkg::MODE_BYPASS && !n.holder_valid && n.count != 0)
    begin
      n.holder       = rd_data;
      n.holder_valid = 1'b1;
      n.rd_ptr       = n.rd_ptr + PW'(1);
      n.count        = n.count - (PW+1)'(1);
      n.overrun      = 1'b0;
    end
    // Push after pop so a full stream buffer drops only one entry.
    if (sample_valid)
    begin
      // Live data is not a buffered entry, so it must never block the
      // first pop once a buffered mode is entered.
      if (mode == asft_pkg::MODE_BYPASS)
        n.holder = sample_data;
      else
      begin
        drop = mode == asft_pkg::MODE_STREAM ||
               (mode == asft_pkg::MODE_TRIGGER && !n.triggered);
        if (n.count < (PW+1)'(DEPTH))
        begin
          wr_en   = 1'b1;
          n.count = n.count + (PW+1)'(1);
        end
        else if (drop)
        begin
          wr_en    = 1'b1;
          n.rd_ptr = n.rd_ptr + PW'(1);
        end
        // Plain FIFO and post-trigger modes just stop storing.
        if (wr_en)
          n.wr_ptr = n.wr_ptr + PW'(1);
      end
    end
    // Only the first trigger after arming trims the history.
    if (trigger_event && mode == asft_pkg::MODE_TRIGGER && !n.triggered)
    begin
      n.triggered = 1'b1;
      if (n.count > level)
      begin
        n.rd_ptr = n.wr_ptr - level[PW-1:0];
        n.count  = level;
      end
    end
    // Overrun set wins over the clear made by a pop in the same cycle.
    if (mode != asft_pkg::MODE_BYPASS && n.count == (PW+1)'(DEPTH))
      n.overrun = 1'b1;
    n.watermark = mode != asft_pkg::MODE_BYPASS && n.count >= level;
    n.int_one   = n.triggered & ~n.ctrl[asft_pkg::CTRL_TRIG_SEL];
    n.int_two   = n.triggered & n.ctrl[asft_pkg::CTRL_TRIG_SEL];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q      <= '0;
      q.s1   <= PIN_IDLE;
      q.s2   <= PIN_IDLE;
      q.s3   <= PIN_IDLE;
      q.pin  <= PIN_IDLE;
      q.ctrl <= asft_pkg::CTRL_RESET;
    end
    else
      q <= n;
  end

  assign interrupt_out_one = q.int_one;
  assign interrupt_out_two = q.int_two;
  assign watermark         = q.watermark;
  assign overrun           = q.overrun;
  assign link.miso         = q.miso;
  assign link.miso_oe      = q.miso_oe;
endmodule // asft_dev_end

// File: src/asft_host_end.sv
// Host end: APB-controlled serial master that runs buffer transfers.
`timescale 1ns/1ps
module asft_host_end #(
  parameter int SCLK_HALF = asft_pkg::SCLK_HALF_DEF
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link.
  asft_link_if.host        link
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (SCLK_HALF < asft_pkg::SCLK_HALF_MIN || SCLK_HALF > 65535)
    $error("SCLK_HALF out of range for the sensor edge detector");

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_LEAD  = 4'b0010,
    H_SHIFT = 4'b0100,
    H_GUARD = 4'b1000
  } asft_hstate_e;

  typedef struct packed {
    asft_hstate_e state;
    logic [15:0]  div;
    logic [5:0]   bits;
    logic [9:0]   guard;
    logic [18:0]  cmd;
    logic [15:0]  tx;
    logic [47:0]  rx;
    logic         sclk;
    logic         cs_n;
    logic         mosi;
    logic [2:0]   ms;
    logic         miso_f;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } asft_host_s;

  localparam logic [15:0] HALF_LOAD = 16'(SCLK_HALF - 1);
  localparam logic [9:0]  GUARD_CYC = 10'(asft_pkg::POP_DELAY_CYC);

  asft_host_s q;
  asft_host_s n;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic tick;
    logic acc;
    n        = q;
    acc      = psel && penable;
    // Miso capture; a level counts once stages two and three agree.
    n.ms     = {q.ms[1:0], link.miso};
    if (q.ms[1] == q.ms[2])
      n.miso_f = q.ms[2];
    tick     = q.div == 16'h0000;
    n.div    = tick ? HALF_LOAD : q.div - 16'h0001;
    // One wait state: read data and the answer are registered.
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (acc && !q.pready)
    begin
      n.pready = 1'b1;
      case (paddr)
        asft_pkg::HREG_CMD:    n.prdata = {13'h0000, q.cmd};
        asft_pkg::HREG_RX_LO:  n.prdata = q.rx[31:0];
        asft_pkg::HREG_RX_HI:  n.prdata = {16'h0000, q.rx[47:32]};
        asft_pkg::HREG_STATUS: n.prdata = {31'h00000000,
                                           q.state != H_IDLE};
        default:
        begin
          n.prdata  = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    unique case (q.state)
      H_IDLE:
      begin
        // Commands while busy are dropped; software polls busy first.
        if (acc && q.pready && pwrite && paddr == asft_pkg::HREG_CMD)
        begin
          n.cmd   = pwdata[18:0];
          n.tx    = pwdata[15:0];
          n.bits  = {pwdata[18:16] + 3'h1, 3'h0};
          n.rx    = '0;
          n.cs_n  = 1'b0;
          n.div   = HALF_LOAD;
          n.state = H_LEAD;
        end
      end
      H_LEAD:
        if (tick)
          n.state = H_SHIFT;
      H_SHIFT:
        if (tick)
        begin
          if (q.sclk)
          begin
            n.sclk = 1'b0;
            n.mosi = q.tx[15];
            n.tx   = {q.tx[14:0], 1'b0};
          end
          else
          begin
            n.sclk = 1'b1;
            n.rx   = {q.rx[46:0], n.miso_f};
            n.bits = q.bits - 6'h01;
            if (q.bits == 6'h01)
            begin
              n.guard = '0;
              n.state = H_GUARD;
            end
          end
        end
      H_GUARD:
      begin
        // Deselect after every transfer, then hold off the next one
        // so the sensor finishes its pop or trigger trim.
        if (tick && !q.cs_n)
          n.cs_n = 1'b1;
        if (q.cs_n)
          n.guard = q.guard + 10'h001;
        if (q.cs_n && q.guard == GUARD_CYC - 10'h001)
          n.state = H_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q       <= '0;
      q.state <= H_IDLE;
      q.sclk  <= 1'b1;
      q.cs_n  <= 1'b1;
    end
    else
      q <= n;
  end

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.mosi = q.mosi;
endmodule // asft_host_end

// File: sim/asft_link_checker.sv
// Concurrent checks on the link wires and the sensor end's event pins.
`timescale 1ns/1ps
module asft_link_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Link wires.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  // Sensor end pins.
  input wire logic sample_valid,
  input wire logic trigger_event,
  input wire logic interrupt_out_one,
  input wire logic interrupt_out_two,
  input wire logic watermark,
  input wire logic overrun
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [3:0] trig_age_q;
  logic [3:0] cs_age_q;
  logic       cs_near;
  logic       int_any;

  // Saturating ages, so a long idle stretch never wraps into a false match.
  always_ff @(posedge ref_clk)
  begin
    trig_age_q <= srst ? 4'hF : trigger_event ? 4'h0 :
                  trig_age_q + {3'h0, ~&trig_age_q};
    cs_age_q   <= (srst || !cs_n) ? 4'h0 : cs_age_q + {3'h0, ~&cs_age_q};
  end

  // Register traffic ends a few filter cycles after select rises.
  assign cs_near = cs_age_q < 4'hC;
  assign int_any = interrupt_out_one | interrupt_out_two;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_int_excl: assert property (!(interrupt_out_one && interrupt_out_two))
    else $error("both trigger outputs high");
  a_int_cause: assert property ($rose(int_any) |-> trig_age_q < 4'h4 || cs_near)
    else $error("trigger output rose without a trigger");
  a_int_hold: assert property ($fell(int_any) |-> cs_near)
    else $error("trigger output dropped without re-arm traffic");
  a_wm_rise: assert property ($rose(watermark) |-> $past(sample_valid) ||
    $past(sample_valid, 2) || $past(sample_valid, 3) || cs_near)
    else $error("watermark rose without a new sample");
  a_wm_hold: assert property ($fell(watermark) |-> cs_near)
    else $error("watermark fell without a read");
  a_ovr_rise: assert property ($rose(overrun) |-> $past(sample_valid) ||
    $past(sample_valid, 2) || $past(sample_valid, 3))
    else $error("overrun rose without a new sample");
  a_ovr_fall: assert property ($fell(overrun) |-> cs_near)
    else $error("overrun fell without a read");
  a_oe_off: assert property (cs_n [*5] |-> !miso_oe)
    else $error("sensor drives data while deselected");
  a_sclk_idle: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  a_sclk_low: assert property ($fell(sclk) |=> !sclk [*7])
    else $error("serial clock low phase too short");
  a_miso_steady: assert property (miso_oe && $rose(sclk) |-> $stable(miso))
    else $error("sensor data moved at the sampling edge");
  a_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("host data moved at the sampling edge");
endmodule // asft_link_checker

// File: sim/accel_sample_fifo_stream_trigger_tb.sv
// Self-checking bench joining the host end and the sensor end.
`timescale 1ns/1ps
module accel_sample_fifo_stream_trigger_tb;
  logic        ref_clk, interrupt_out_one, interrupt_out_two;
  logic        srst = 1'b1, sample_valid = 1'b0, trigger_event = 1'b0;
  logic [47:0] sample_data = 48'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic        pready, pslverr, watermark, overrun, perr;
  int          miscompares = 0, n_compared = 0, cyc = 0, seed = 85542;
  // Behavioural model: queue behind the output bytes, plus mode state.
  logic [47:0] q[$];
  logic [47:0] mout = 48'h0, rx;
  logic [1:0]  mode = 2'h0;
  logic [4:0]  lvl = 5'h00;
  logic        sel = 1'b0, trg = 1'b0, movr = 1'b0, outv = 1'b0;

  asft_link_if link_i ();
  asft_dev_end asft_dev_end_i (.ref_clk, .srst, .sample_valid, .sample_data,
    .trigger_event, .interrupt_out_one, .interrupt_out_two, .watermark,
    .overrun, .link(link_i));
  // The shortest safe serial half period keeps the run brief.
  asft_host_end #(.SCLK_HALF(8)) asft_host_end_i (.ref_clk, .srst, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .link(link_i));
  asft_link_checker asft_link_checker_i (.ref_clk, .srst,
    .sclk(link_i.sclk), .cs_n(link_i.cs_n), .mosi(link_i.mosi),
    .miso(link_i.miso), .miso_oe(link_i.miso_oe), .sample_valid,
    .trigger_event, .interrupt_out_one, .interrupt_out_two, .watermark,
    .overrun);

  // Clock generator.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // A hang is cut short well after the expected run length.
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start a serial frame, wait until idle, then fetch what came back.
  task automatic xfer(input logic [7:0] c, input logic [7:0] d,
                      input int n, output logic [47:0] r);
    logic [31:0] lo;
    logic [31:0] hi;
    // The host shifts command bits 15 down to 0, so the first byte is high.
    apb(1'b1, asft_pkg::HREG_CMD, {13'h0, 3'(n), c, d}, hi);
    do apb(1'b0, asft_pkg::HREG_STATUS, 32'h0, hi); while (hi[0] !== 1'b0);
    apb(1'b0, asft_pkg::HREG_RX_LO, 32'h0, lo);
    apb(1'b0, asft_pkg::HREG_RX_HI, 32'h0, hi);
    r = {hi[15:0], lo};
  endtask

  task automatic wctl(input logic [7:0] c);
    xfer(8'h38, c, 1, rx);
    xfer(8'hB8, 8'h00, 1, rx);
    chk(rx[7:0], c);
    mode = c[7:6];
    sel = c[5];
    lvl = c[4:0];
    if (c[7:6] == 2'h0)
    begin
      q.delete();
      outv = 1'b0;
      trg = 1'b0;
      movr = 1'b0;
    end
  endtask

  task automatic stat();
    xfer(8'hB9, 8'h00, 1, rx);
    chk(rx[7:0], {trg, 1'b0, 6'(q.size())});
  endtask

  // Six-byte burst or single-byte read of the output bytes.
  task automatic rdsmp(input int n);
    logic [47:0] e;
    e = {mout[7:0], mout[15:8], mout[23:16], mout[31:24], mout[39:32],
         mout[47:40]};
    xfer(n == 6 ? 8'hF2 : 8'hB2, 8'h00, n, rx);
    if (n == 6)
      chk(rx, e);
    else
      chk(rx[7:0], e[47:40]);
    if (mode != 2'h0)
    begin
      if (q.size() > 0)
        mout = q.pop_front();
      else
        outv = 1'b0;
      movr = 1'b0;
    end
    chk(overrun, movr);
  endtask

  task automatic push(input int n);
    logic [63:0] r;
    repeat (n)
    begin
      r = {$random(seed), $random(seed)};
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample_data  <= r[47:0];
      if (mode == 2'h0 || !outv)
      begin
        mout = r[47:0];
        outv = mode != 2'h0;
      end
      else if (q.size() < 32 || mode == 2'h2 || (mode == 2'h3 && !trg))
      begin
        if (q.size() == 32)
          void'(q.pop_front());
        q.push_back(r[47:0]);
        movr = movr | (q.size() == 32);
      end
    end
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(watermark, mode != 2'h0 && q.size() >= lvl);
    chk(overrun, movr);
  endtask

  task automatic trig();
    @(posedge ref_clk);
    trigger_event <= 1'b1;
    @(posedge ref_clk);
    trigger_event <= 1'b0;
    if (mode == 2'h3 && !trg)
    begin
      trg = 1'b1;
      while (q.size() > lvl)
        void'(q.pop_front());
    end
    // Leave the buffer time to trim before anything is read.
    repeat (1000) @(posedge ref_clk);
    chk(interrupt_out_one, trg && !sel);
    chk(interrupt_out_two, trg && sel);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, 8'h10, 32'h0, v);
    chk(v, 48'h0);
    chk(perr, 1'b1);
    push(1);
    rdsmp(6);
    stat();
    $display("test bypass done");
    wctl(8'h85);
    push(5);
    push(1);
    push(40);
    stat();
    rdsmp(6);
    rdsmp(1);
    rdsmp(6);
    stat();
    $display("test stream done");
    wctl(8'h00);
    stat();
    wctl(8'h5F);
    push(40);
    stat();
    rdsmp(6);
    $display("test fifo done");
    for (int k = 0; k < 2; k++)
    begin
      wctl(8'h00);
      wctl(k == 0 ? 8'hE4 : 8'hC4);
      push(10);
      trig();
      stat();
      push(2);
      trig();
      stat();
      rdsmp(6);
      $display("test trigger %0d done", k);
    end
    end_of_test();
  end
endmodule // accel_sample_fifo_stream_trigger_tb
